// ---- hdl/tmr_timer16.sv ----
// 16-bit timer with dual 8-bit mode, flag register, irq gating and Avalon-MM slave
// How it works
// - Normal mode: wrap flag sets when counter hits top or bottom.
// - Normal mode: channel n match flag sets when counter equals compare n.
// - Dual mode: low underflow flag sets when low byte reaches bottom.
// - Dual mode: separate high underflow flag when high byte reaches bottom.
// - Dual mode: low match flag n when low byte equals compare n low byte.
// - Flags set on every event, whether or not enabled.
// - Software writes enable bits; hardware honours them for requests.
// - Request asserted only where enable and flag are both set.
// - Request is a level held until the flag is cleared.
// - Counting, flags and requests continue in idle sleep.
// - Dual select bit splits timer into two 8-bit timers; register offsets stay the same.
// - Dual mode: no compare flag for high-byte compares.
// - Event pulses use exactly the flag-setting conditions in both modes.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"

module tmr_timer16 (
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    input  wire logic [5:0]       AVS_ADDRESS,
    input  wire logic             AVS_READ,
    input  wire logic             AVS_WRITE,
    input  wire logic [31:0]      AVS_WRITEDATA,
    input  wire logic [3:0]       AVS_BYTEENABLE,
    output logic [31:0]           AVS_READDATA,
    output logic                  AVS_WAITREQUEST,
    output logic                  IRQ_REQ,
    output tmr_pkg::tmr_evt_t     EVT
);

    tmr_pkg::tmr_state_t s;
    tmr_pkg::tmr_state_t next_s;

    function automatic tmr_pkg::tmr_state_t reset_regs(input tmr_pkg::tmr_state_t cur);
        tmr_pkg::tmr_state_t r;
        r             = '0;
        r.top         = `TMR_RST_TOP;
        r.ack         = cur.ack;
        r.rdata       = cur.rdata;
        reset_regs    = r;
    endfunction

    function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] be, input logic [7:0] msk);
        wr8 = be[0] ? (wd[7:0] & msk) : old;
    endfunction

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        wr16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic [31:0] rd(input tmr_pkg::tmr_state_t c, input logic [5:0] a);
        rd = 32'h0000_0000;
        case (a)
            `TMR_OFS_CLK_EN:    rd[7:0]  = c.clk_en;
            `TMR_OFS_WAVE:      rd[7:0]  = c.wave;
            `TMR_OFS_OVERRIDE:  rd[7:0]  = c.override;
            `TMR_OFS_SPLIT:     rd[7:0]  = c.split;
            `TMR_OFS_DIR_CLR,
            `TMR_OFS_DIR_SET:   rd[7:0]  = c.dir;
            `TMR_OFS_BV_CLR,
            `TMR_OFS_BV_SET:    rd[7:0]  = c.buf_valid;
            `TMR_OFS_EVT_SETUP: rd[7:0]  = c.evt_setup;
            `TMR_OFS_IRQ_EN:    rd[7:0]  = c.irq_enable;
            `TMR_OFS_IRQ_PEND:  rd[7:0]  = c.irq_pending;
            `TMR_OFS_DBG:       rd[7:0]  = c.dbg;
            `TMR_OFS_TEMP:      rd[7:0]  = c.temp;
            `TMR_OFS_CNT:       rd[15:0] = c.cnt;
            `TMR_OFS_TOP:       rd[15:0] = c.top;
            `TMR_OFS_COMPARE0_VALUE:      rd[15:0] = c.cmp[0];
            `TMR_OFS_COMPARE1_VALUE:      rd[15:0] = c.cmp[1];
            `TMR_OFS_COMPARE2_VALUE:      rd[15:0] = c.cmp[2];
            `TMR_OFS_TOP_BUF:   rd[15:0] = c.top_buf;
            `TMR_OFS_COMPARE0_VALUE_BUF:  rd[15:0] = c.cmp_buf[0];
            `TMR_OFS_COMPARE1_VALUE_BUF:  rd[15:0] = c.cmp_buf[1];
            `TMR_OFS_COMPARE2_VALUE_BUF:  rd[15:0] = c.cmp_buf[2];
            default:            rd       = 32'h0000_0000;
        endcase
    endfunction

    always_comb begin
        logic             run;
        logic             dual;
        logic             down;
        logic             wr;
        logic [7:0]       set_bits;
        logic [7:0]       clr_bits;
        logic [7:0]       irq_msk;
        logic [1:0]       cmd;
        tmr_pkg::tmr_evt_t ev;
        next_s   = s;
        // Nothing gates on sleep state, so idle sleep leaves counting alone
        run      = s.clk_en[`TMR_BIT_ENABLE];
        dual     = s.split[`TMR_BIT_DUAL];
        down     = s.dir[`TMR_BIT_DIR];
        wr       = AVS_WRITE & s.ack;
        cmd      = AVS_WRITEDATA[`TMR_CMD_LSB +: 2];
        irq_msk  = dual ? `TMR_MSK_IRQ_DUAL : `TMR_MSK_IRQ_NORMAL;
        ev       = '0;
        set_bits = 8'h00;
        clr_bits = 8'h00;

        next_s.ack = (AVS_READ | AVS_WRITE) & ~s.ack;
        if (AVS_READ && !s.ack) begin
            next_s.rdata = rd(s, AVS_ADDRESS);
        end

        if (run && !dual) begin
            if (down) begin
                ev.wrap_low_half_underflow = (s.cnt == 16'h0000);
                next_s.cnt   = ev.wrap_low_half_underflow ? s.top : s.cnt - 16'h0001;
            end else begin
                ev.wrap_low_half_underflow = (s.cnt == s.top);
                next_s.cnt   = ev.wrap_low_half_underflow ? 16'h0000 : s.cnt + 16'h0001;
            end
            for (int i = 0; i < 3; i++) begin
                ev.match[i] = (s.cnt == s.cmp[i]);
            end
        end else if (run) begin
            // Both halves count down only, each reloading from its own top byte
            ev.wrap_low_half_underflow = (s.cnt[7:0] == 8'h00);
            ev.high_half_underflow      = (s.cnt[15:8] == 8'h00);
            next_s.cnt[7:0]  = ev.wrap_low_half_underflow ? s.top[7:0] : s.cnt[7:0] - 8'h01;
            next_s.cnt[15:8] = ev.high_half_underflow ? s.top[15:8] : s.cnt[15:8] - 8'h01;
            for (int i = 0; i < 3; i++) begin
                // High compare bytes raise nothing in this mode
                ev.match[i] = (s.cnt[7:0] == s.cmp[i][7:0]);
            end
        end
        next_s.evt = ev;

        set_bits[`TMR_BIT_WRAP_LOW_HALF_UNDERFLOW]      = ev.wrap_low_half_underflow;
        set_bits[`TMR_BIT_HIGH_HALF_UNDERFLOW]           = ev.high_half_underflow & dual;
        set_bits[`TMR_BIT_MATCH0 +: 3]    = ev.match;

        if (wr) begin
            case (AVS_ADDRESS)
                `TMR_OFS_CLK_EN:    next_s.clk_en = wr8(s.clk_en, AVS_WRITEDATA,
                                                       AVS_BYTEENABLE, `TMR_MSK_CLK_EN);
                `TMR_OFS_WAVE:      next_s.wave = wr8(s.wave, AVS_WRITEDATA,
                                                     AVS_BYTEENABLE, `TMR_MSK_WAVE);
                `TMR_OFS_OVERRIDE:  next_s.override = wr8(s.override, AVS_WRITEDATA,
                                                         AVS_BYTEENABLE, `TMR_MSK_OVERRIDE);
                `TMR_OFS_SPLIT:     next_s.split = wr8(s.split, AVS_WRITEDATA,
                                                      AVS_BYTEENABLE, `TMR_MSK_SPLIT);
                `TMR_OFS_DIR_CLR:   if (AVS_BYTEENABLE[0]) begin
                    next_s.dir = s.dir & ~(AVS_WRITEDATA[7:0] & `TMR_MSK_DIR);
                end
                `TMR_OFS_DIR_SET:   if (AVS_BYTEENABLE[0]) begin
                    next_s.dir = s.dir | (AVS_WRITEDATA[7:0] & `TMR_MSK_DIR);
                end
                `TMR_OFS_BV_CLR:    if (AVS_BYTEENABLE[0]) begin
                    next_s.buf_valid = s.buf_valid & ~(AVS_WRITEDATA[7:0] & `TMR_MSK_BV);
                end
                `TMR_OFS_BV_SET:    if (AVS_BYTEENABLE[0]) begin
                    next_s.buf_valid = s.buf_valid | (AVS_WRITEDATA[7:0] & `TMR_MSK_BV);
                end
                `TMR_OFS_EVT_SETUP: next_s.evt_setup = wr8(s.evt_setup, AVS_WRITEDATA,
                                                          AVS_BYTEENABLE, `TMR_MSK_EVT_SETUP);
                `TMR_OFS_IRQ_EN:    next_s.irq_enable = wr8(s.irq_enable, AVS_WRITEDATA,
                                                           AVS_BYTEENABLE, irq_msk);
                `TMR_OFS_IRQ_PEND:  if (AVS_BYTEENABLE[0]) begin
                    clr_bits = AVS_WRITEDATA[7:0];
                end
                `TMR_OFS_DBG:       next_s.dbg = wr8(s.dbg, AVS_WRITEDATA,
                                                    AVS_BYTEENABLE, `TMR_MSK_DBG);
                `TMR_OFS_TEMP:      next_s.temp = wr8(s.temp, AVS_WRITEDATA,
                                                     AVS_BYTEENABLE, 8'hff);
                `TMR_OFS_CNT:       next_s.cnt = wr16(s.cnt, AVS_WRITEDATA, AVS_BYTEENABLE);
                `TMR_OFS_TOP:       next_s.top = wr16(s.top, AVS_WRITEDATA, AVS_BYTEENABLE);
                `TMR_OFS_COMPARE0_VALUE:      next_s.cmp[0] = wr16(s.cmp[0], AVS_WRITEDATA,
                                                        AVS_BYTEENABLE);
                `TMR_OFS_COMPARE1_VALUE:      next_s.cmp[1] = wr16(s.cmp[1], AVS_WRITEDATA,
                                                        AVS_BYTEENABLE);
                `TMR_OFS_COMPARE2_VALUE:      next_s.cmp[2] = wr16(s.cmp[2], AVS_WRITEDATA,
                                                        AVS_BYTEENABLE);
                `TMR_OFS_TOP_BUF: begin
                    next_s.top_buf = wr16(s.top_buf, AVS_WRITEDATA, AVS_BYTEENABLE);
                    next_s.buf_valid[`TMR_BIT_TOP_BV] = 1'b1;
                end
                `TMR_OFS_COMPARE0_VALUE_BUF,
                `TMR_OFS_COMPARE1_VALUE_BUF,
                `TMR_OFS_COMPARE2_VALUE_BUF: begin
                    for (int i = 0; i < 3; i++) begin
                        if (AVS_ADDRESS == `TMR_OFS_COMPARE0_VALUE_BUF + 6'(2 * i)) begin
                            next_s.cmp_buf[i] = wr16(s.cmp_buf[i], AVS_WRITEDATA,
                                                     AVS_BYTEENABLE);
                            next_s.buf_valid[`TMR_BIT_COMPARE0_VALUE_BV + i] = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Set beats clear so a match in the clearing cycle is not lost
        next_s.irq_pending = ((s.irq_pending & ~clr_bits) | set_bits) & irq_msk;

        // Commands are ignored on the clear register; they act via the set register
        if (wr && AVS_ADDRESS == `TMR_OFS_DIR_SET && AVS_BYTEENABLE[0]) begin
            case (cmd)
                `TMR_CMD_UPDATE: begin
                    next_s.top       = s.top_buf;
                    next_s.cmp       = s.cmp_buf;
                    next_s.buf_valid = 8'h00;
                end
                `TMR_CMD_RESTART: begin
                    next_s.cnt              = 16'h0000;
                    next_s.dir[`TMR_BIT_DIR] = 1'b0;
                end
                `TMR_CMD_RESET: begin
                    // Hard reset only while stopped
                    if (!run) begin
                        next_s = reset_regs(next_s);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s     <= '0;
            s.top <= `TMR_RST_TOP;
        end else begin
            s <= next_s;
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
    assign AVS_READDATA    = s.rdata;
    assign IRQ_REQ         = |(s.irq_enable & s.irq_pending);
    assign EVT             = s.evt;

endmodule // tmr_timer16

`default_nettype wire

// ---- shared/tmr_map.svh ----
// Register offsets, field positions, masks and reset values of the timer block
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_OFS_CLK_EN      6'h00
`define TMR_OFS_WAVE        6'h01
`define TMR_OFS_OVERRIDE    6'h02
`define TMR_OFS_SPLIT       6'h03
`define TMR_OFS_DIR_CLR     6'h04
`define TMR_OFS_DIR_SET     6'h05
`define TMR_OFS_BV_CLR      6'h06
`define TMR_OFS_BV_SET      6'h07
`define TMR_OFS_EVT_SETUP   6'h09
`define TMR_OFS_IRQ_EN      6'h0a
`define TMR_OFS_IRQ_PEND    6'h0b
`define TMR_OFS_DBG         6'h0e
`define TMR_OFS_TEMP        6'h0f
`define TMR_OFS_CNT         6'h20
`define TMR_OFS_TOP         6'h26
`define TMR_OFS_COMPARE0_VALUE        6'h28
`define TMR_OFS_COMPARE1_VALUE        6'h2a
`define TMR_OFS_COMPARE2_VALUE        6'h2c
`define TMR_OFS_TOP_BUF     6'h36
`define TMR_OFS_COMPARE0_VALUE_BUF    6'h38
`define TMR_OFS_COMPARE1_VALUE_BUF    6'h3a
`define TMR_OFS_COMPARE2_VALUE_BUF    6'h3c

`define TMR_BIT_ENABLE      0
`define TMR_BIT_DUAL        0
`define TMR_BIT_DIR         0
`define TMR_BIT_LUPD        1
`define TMR_BIT_WRAP_LOW_HALF_UNDERFLOW   0
`define TMR_BIT_HIGH_HALF_UNDERFLOW        1
`define TMR_BIT_MATCH0      4
`define TMR_BIT_TOP_BV      0
`define TMR_BIT_COMPARE0_VALUE_BV     1

`define TMR_MSK_CLK_EN      8'h0f
`define TMR_MSK_WAVE        8'h7f
`define TMR_MSK_OVERRIDE    8'h07
`define TMR_MSK_SPLIT       8'h01
`define TMR_MSK_DIR         8'h03
`define TMR_MSK_BV          8'h0f
`define TMR_MSK_EVT_SETUP   8'h07
`define TMR_MSK_IRQ_NORMAL  8'h71
`define TMR_MSK_IRQ_DUAL    8'h73
`define TMR_MSK_DBG         8'h01

`define TMR_CMD_LSB         2
`define TMR_CMD_UPDATE      2'h1
`define TMR_CMD_RESTART     2'h2
`define TMR_CMD_RESET       2'h3

`define TMR_RST_BYTE        8'h00
`define TMR_RST_WORD        16'h0000
`define TMR_RST_TOP         16'hffff

`endif

// ---- shared/tmr_pkg.sv ----
// Types shared by the timer block and its bench
package tmr_pkg;

    typedef struct packed {
        logic       wrap_low_half_underflow;
        logic       high_half_underflow;
        logic [2:0] match;
    } tmr_evt_t;

    typedef struct packed {
        logic [7:0]       clk_en;
        logic [7:0]       wave;
        logic [7:0]       override;
        logic [7:0]       split;
        logic [7:0]       dir;
        logic [7:0]       buf_valid;
        logic [7:0]       evt_setup;
        logic [7:0]       irq_enable;
        logic [7:0]       irq_pending;
        logic [7:0]       dbg;
        logic [7:0]       temp;
        logic [15:0]      cnt;
        logic [15:0]      top;
        logic [2:0][15:0] cmp;
        logic [15:0]      top_buf;
        logic [2:0][15:0] cmp_buf;
        logic             ack;
        logic [31:0]      rdata;
        tmr_evt_t         evt;
    } tmr_state_t;

endpackage

// ---- tb/tmr_timer16_assertions.sv ----
// Bus and interrupt checker for the timer block
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_assertions (
    input wire logic              CLK,
    input wire logic              SYS_RST,
    input wire logic [5:0]        AVS_ADDRESS,
    input wire logic              AVS_READ,
    input wire logic              AVS_WRITE,
    input wire logic [31:0]       AVS_WRITEDATA,
    input wire logic [3:0]        AVS_BYTEENABLE,
    input wire logic [31:0]       AVS_READDATA,
    input wire logic              AVS_WAITREQUEST,
    input wire logic              IRQ_REQ,
    input wire tmr_pkg::tmr_evt_t EVT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic       wr_take;
    logic       rd_take;
    logic       dual;
    logic [7:0] en;
    assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;
    assign rd_take = AVS_READ && !AVS_WAITREQUEST;
    // Shadow of mode and enables; hard-reset command not modelled
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dual <= 1'b0;
            en   <= 8'h00;
        end else begin
            if (wr_take && AVS_ADDRESS == 6'h03 && AVS_BYTEENABLE[0]) begin
                dual <= AVS_WRITEDATA[0];
            end
            if (wr_take && AVS_ADDRESS == 6'h0a && AVS_BYTEENABLE[0]) begin
                en <= AVS_WRITEDATA[7:0];
            end
        end
    end
    sequence req_waiting;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    wait_once_a: assert property (req_waiting |=> !AVS_WAITREQUEST)
        else $error("request waited more than one cycle");
    irq_rise_a: assert property ($rose(IRQ_REQ) |->
        (EVT != 5'h00) || $past(wr_take && AVS_ADDRESS == 6'h0a))
        else $error("request rose without event or enable write");
    irq_hold_a: assert property ($fell(IRQ_REQ) |->
        $past(wr_take && AVS_ADDRESS inside {6'h03, 6'h05, 6'h0a, 6'h0b}))
        else $error("request dropped on its own");
    high_half_underflow_dual_a: assert property (!dual && !$past(dual) |-> !EVT.high_half_underflow)
        else $error("high underflow in normal mode");
    evt_irq_a: assert property (((EVT & {en[0], en[1], en[6:4]}) != 5'h00)
        && !$past(wr_take) |-> IRQ_REQ)
        else $error("enabled event without request");
    rdata_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed without a read");
    unmapped_zero_a: assert property (rd_take && AVS_ADDRESS == 6'h08 |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    narrow_zero_a: assert property (rd_take && AVS_ADDRESS < 6'h10 |-> AVS_READDATA[31:8] == 24'h0)
        else $error("byte register upper bits not zero");
endmodule // tmr_timer16_assertions
bind tmr_timer16 tmr_timer16_assertions u_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ_REQ(IRQ_REQ),
    .EVT(EVT)
);
`default_nettype wire

// ---- tb/tmr_irq_ctrl_model.sv ----
// Interrupt controller model counting request assertions
`timescale 1ns/1ps
`default_nettype none
module tmr_irq_ctrl_model (
    input  wire logic  CLK,
    input  wire logic  SYS_RST,
    input  wire logic  IRQ_REQ,
    output logic [7:0] irq_rises
);
    logic last;
    // Edge-counting: a held request is one interrupt, not many
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            last      <= 1'b0;
            irq_rises <= 8'h00;
        end else begin
            last <= IRQ_REQ;
            if (IRQ_REQ && !last) begin
                irq_rises <= irq_rises + 8'h01;
            end
        end
    end
endmodule // tmr_irq_ctrl_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Register-level bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tb_top;
    logic              clk = 1'b0;
    logic              sys_rst;
    logic [5:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              irq_req;
    tmr_pkg::tmr_evt_t evt;
    logic [7:0]        irq_rises;
    logic [31:0]       q;
    int                n_errors = 0;
    int                total_checks = 0;
    int                cycles = 0;

    tmr_timer16 DUT (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .IRQ_REQ(irq_req), .EVT(evt));
    tmr_irq_ctrl_model u_irq (.CLK(clk), .SYS_RST(sys_rst), .IRQ_REQ(irq_req),
        .irq_rises(irq_rises));

    always #20 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (n >= 16) n_errors++;
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    // Request settles after the taking edge
    task automatic irq_is(input logic e);
        @(negedge clk);
        check({31'h0, irq_req}, {31'h0, e});
    endtask

    task automatic run(input int n);
        bus(1'b1, `TMR_OFS_CLK_EN, 32'h1);
        repeat (n) @(posedge clk);
        bus(1'b1, `TMR_OFS_CLK_EN, 32'h0);
    endtask

    initial begin
        sys_rst        = 1'b1;
        avs_address    = 6'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h3;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(`TMR_OFS_IRQ_EN, 32'h0);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h0);
        rd_chk(`TMR_OFS_TOP, 32'h0000ffff);
        rd_chk(6'h08, 32'h0);
        $display("test reset_values done");
        bus(1'b1, `TMR_OFS_TOP, 32'h10);
        bus(1'b1, `TMR_OFS_COMPARE0_VALUE, 32'h5);
        bus(1'b1, `TMR_OFS_COMPARE1_VALUE, 32'h6);
        bus(1'b1, `TMR_OFS_COMPARE2_VALUE, 32'h7);
        run(60);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h71);
        irq_is(1'b0);
        $display("test normal_flags done");
        bus(1'b1, `TMR_OFS_IRQ_EN, 32'h10);
        irq_is(1'b1);
        bus(1'b1, `TMR_OFS_IRQ_PEND, 32'h00);
        irq_is(1'b1);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h71);
        bus(1'b1, `TMR_OFS_IRQ_PEND, 32'h10);
        irq_is(1'b0);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h61);
        $display("test enable_clear done");
        bus(1'b1, `TMR_OFS_IRQ_PEND, 32'hff);
        bus(1'b1, `TMR_OFS_IRQ_EN, 32'h0);
        bus(1'b1, `TMR_OFS_SPLIT, 32'h1);
        bus(1'b1, `TMR_OFS_CNT, 32'h0);
        bus(1'b1, `TMR_OFS_TOP, 32'h0304);
        bus(1'b1, `TMR_OFS_COMPARE0_VALUE, 32'h0002);
        bus(1'b1, `TMR_OFS_COMPARE1_VALUE, 32'h0003);
        // High byte 2 is reached by the high timer but must raise nothing
        bus(1'b1, `TMR_OFS_COMPARE2_VALUE, 32'h0209);
        run(60);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h33);
        bus(1'b1, `TMR_OFS_IRQ_EN, 32'h02);
        irq_is(1'b1);
        rd_chk(`TMR_OFS_IRQ_EN, 32'h02);
        bus(1'b1, `TMR_OFS_IRQ_PEND, 32'h02);
        irq_is(1'b0);
        rd_chk(`TMR_OFS_IRQ_PEND, 32'h31);
        check({24'h0, irq_rises}, 32'h2);
        $display("test dual_flags done");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
